// *** t16w_map.svh ***
// Constants of the 16-bit timer waveform generator
`ifndef T16W_MAP_SVH
`define T16W_MAP_SVH
// ****************************************
// Counter limits
// ****************************************
`define T16W_MAX 16'hffff
`define T16W_BOTTOM 16'h0000
`define T16W_TOP8 16'h00ff
`define T16W_TOP9 16'h01ff
`define T16W_TOP10 16'h03ff
// ****************************************
// Output mode codes
// ****************************************
`define T16W_COM_OFF 2'h0
`define T16W_COM_TOGGLE 2'h1
`define T16W_COM_NONINV 2'h2
`define T16W_COM_INV 2'h3
// ****************************************
// Prescaler masks (divisor minus one)
// ****************************************
`define T16W_PRE_W 10
`define T16W_DIV8_MASK 10'h007
`define T16W_DIV64_MASK 10'h03f
`define T16W_DIV256_MASK 10'h0ff
`define T16W_DIV1024_MASK 10'h3ff
`define T16W_DIV1_MASK 10'h000
`endif

// *** t16w_pkg.sv ***
// Types shared by the 16-bit timer waveform generator
package t16w_pkg;
   // ****************************************
   // Waveform modes that are implemented
   // ****************************************
   typedef enum logic [3:0] {
      T16W_NORMAL = 4'b0000,
      T16W_CTC_A = 4'b0100,
      T16W_FPWM8 = 4'b0101,
      T16W_FPWM9 = 4'b0110,
      T16W_FPWM10 = 4'b0111,
      T16W_CTC_CAP = 4'b1100,
      T16W_FPWM_CAP = 4'b1110,
      T16W_FPWM_A = 4'b1111
   } t16w_mode_t;
   // ****************************************
   // Prescaler selections
   // ****************************************
   typedef enum logic [2:0] {
      T16W_STOP = 3'b000,
      T16W_DIV1 = 3'b001,
      T16W_DIV8 = 3'b010,
      T16W_DIV64 = 3'b011,
      T16W_DIV256 = 3'b100,
      T16W_DIV1024 = 3'b101
   } t16w_pre_t;
   // Source of TOP
   typedef enum logic [1:0] {
      T16W_TOP_MAX = 2'b00,
      T16W_TOP_FIXED = 2'b01,
      T16W_TOP_CMPA = 2'b10,
      T16W_TOP_CAP = 2'b11
   } t16w_top_t;
   // Decoded mode properties
   typedef struct packed {
      logic pwm;
      t16w_top_t top_src;
      logic [15:0] fixed_top;
   } t16w_dec_t;
   // A 16-bit register write strobe with its data
   typedef struct packed {
      logic strobe;
      logic [15:0] data;
   } t16w_wr_t;
   // Sticky event flags
   typedef struct packed {
      logic overflow;
      logic capture;
      logic [1:0] match;
   } t16w_flags_t;
endpackage

// *** t16w_timer.sv ***
// Counter, prescaler, compare channels and waveform outputs of the 16-bit timer
`timescale 1ns/1ps
`include "t16w_map.svh"
module t16w_timer #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Configuration
   input wire logic [3:0] waveform_mode_select_in,
   input wire logic [2:0] clock_select_in,
   input wire logic [CHANNELS-1:0][1:0] compare_output_mode_in,
   input wire logic [CHANNELS-1:0] pin_direction_in,
   // Register writes
   input wire t16w_pkg::t16w_wr_t counter_wr_in,
   input wire t16w_pkg::t16w_wr_t capture_wr_in,
   input wire t16w_pkg::t16w_wr_t [CHANNELS-1:0] compare_wr_in,
   input wire logic [CHANNELS-1:0] force_compare_strobe_in,
   // Flag clears (servicing or software)
   input wire t16w_pkg::t16w_flags_t flag_clear_in,
   // Register views
   output logic [15:0] counter_value_out,
   output logic [15:0] capture_value_out,
   output logic [CHANNELS-1:0][15:0] compare_value_out,
   output t16w_pkg::t16w_flags_t flags_out,
   // Waveform and pins
   output logic [CHANNELS-1:0] compare_output_bit_out,
   output logic [CHANNELS-1:0] pin_level_out,
   output logic [CHANNELS-1:0] pin_oe_out
);
   // ****************************************
   // Decoding functions
   // ****************************************
   // Modes not listed fall back to plain up counting
   function automatic t16w_pkg::t16w_dec_t mode_decode(input logic [3:0] m);
      t16w_pkg::t16w_dec_t d;
      d.pwm = 1'b0;
      d.top_src = t16w_pkg::T16W_TOP_MAX;
      d.fixed_top = `T16W_MAX;
      case (t16w_pkg::t16w_mode_t'(m))
         t16w_pkg::T16W_CTC_A: begin
            d.top_src = t16w_pkg::T16W_TOP_CMPA;
         end
         t16w_pkg::T16W_CTC_CAP: begin
            d.top_src = t16w_pkg::T16W_TOP_CAP;
         end
         t16w_pkg::T16W_FPWM8: begin
            d.pwm = 1'b1;
            d.top_src = t16w_pkg::T16W_TOP_FIXED;
            d.fixed_top = `T16W_TOP8;
         end
         t16w_pkg::T16W_FPWM9: begin
            d.pwm = 1'b1;
            d.top_src = t16w_pkg::T16W_TOP_FIXED;
            d.fixed_top = `T16W_TOP9;
         end
         t16w_pkg::T16W_FPWM10: begin
            d.pwm = 1'b1;
            d.top_src = t16w_pkg::T16W_TOP_FIXED;
            d.fixed_top = `T16W_TOP10;
         end
         t16w_pkg::T16W_FPWM_CAP: begin
            d.pwm = 1'b1;
            d.top_src = t16w_pkg::T16W_TOP_CAP;
         end
         t16w_pkg::T16W_FPWM_A: begin
            d.pwm = 1'b1;
            d.top_src = t16w_pkg::T16W_TOP_CMPA;
         end
         default: begin
            d.pwm = 1'b0;
         end
      endcase
      return d;
   endfunction

   // Bit mask of a written compare value
   function automatic logic [15:0] write_mask(input t16w_pkg::t16w_dec_t d);
      if (d.top_src == t16w_pkg::T16W_TOP_FIXED) begin
         return d.fixed_top;
      end
      return `T16W_MAX;
   endfunction

   // ****************************************
   // Decoded mode
   // ****************************************
   t16w_pkg::t16w_dec_t dec;
   logic [15:0] wmask;
   assign dec = mode_decode(waveform_mode_select_in);
   assign wmask = write_mask(dec);

   // ****************************************
   // Prescaler
   // ****************************************
   logic [`T16W_PRE_W-1:0] pre_ff;
   logic [`T16W_PRE_W-1:0] pre_mask;
   logic pre_run;
   logic tick;

   // Divider selection; divisors are powers of two so a mask suffices
   always_comb begin
      pre_run = 1'b1;
      pre_mask = `T16W_DIV1_MASK;
      case (t16w_pkg::t16w_pre_t'(clock_select_in))
         t16w_pkg::T16W_DIV1: pre_mask = `T16W_DIV1_MASK;
         t16w_pkg::T16W_DIV8: pre_mask = `T16W_DIV8_MASK;
         t16w_pkg::T16W_DIV64: pre_mask = `T16W_DIV64_MASK;
         t16w_pkg::T16W_DIV256: pre_mask = `T16W_DIV256_MASK;
         t16w_pkg::T16W_DIV1024: pre_mask = `T16W_DIV1024_MASK;
         default: pre_run = 1'b0;
      endcase
   end

   // Free-running prescale count shared by all divisors
   // Limitation: a divider change mid-count can shorten the first period
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         pre_ff <= '0;
      end else begin
         pre_ff <= pre_ff + 1'b1;
      end
   end

   assign tick = pre_run && ((pre_ff & pre_mask) == pre_mask);

   // ****************************************
   // Counter and TOP
   // ****************************************
   logic [15:0] cnt_ff;
   logic [15:0] cap_ff;
   logic block_ff;
   logic [15:0] top_value;
   logic [15:0] nxt_cnt;
   logic top_hit;
   logic [CHANNELS-1:0][15:0] ocr_ff;

   // TOP source; channel A active value is the post-buffer one
   always_comb begin
      case (dec.top_src)
         t16w_pkg::T16W_TOP_FIXED: top_value = dec.fixed_top;
         t16w_pkg::T16W_TOP_CMPA: top_value = ocr_ff[0];
         t16w_pkg::T16W_TOP_CAP: top_value = cap_ff;
         default: top_value = `T16W_MAX;
      endcase
   end

   // Equality only, so a TOP written below the count is missed until wrap
   assign top_hit = (dec.top_src != t16w_pkg::T16W_TOP_MAX) && !block_ff &&
      (cnt_ff == top_value);

   // Next count: clear at TOP, else increment with natural 16-bit wrap
   always_comb begin
      if (top_hit) begin
         nxt_cnt = `T16W_BOTTOM;
      end else begin
         nxt_cnt = cnt_ff + 16'h0001;
      end
   end

   // Software write always wins over counting
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cnt_ff <= `T16W_BOTTOM;
      end else if (counter_wr_in.strobe) begin
         cnt_ff <= counter_wr_in.data;
      end else if (tick) begin
         cnt_ff <= nxt_cnt;
      end
   end

   // A counter write hides matches for the next timer cycle, even stopped
   // Lets software preset count and compare equal with no spurious event
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         block_ff <= 1'b0;
      end else if (counter_wr_in.strobe) begin
         block_ff <= 1'b1;
      end else if (tick) begin
         block_ff <= 1'b0;
      end
   end

   // Capture value, never buffered
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         cap_ff <= `T16W_BOTTOM;
      end else if (capture_wr_in.strobe) begin
         cap_ff <= capture_wr_in.data;
      end
   end

   // ****************************************
   // Overflow and capture flags
   // ****************************************
   logic ovf_set;
   logic cap_set;
   logic ovf_ff;
   logic capf_ff;

   // PWM overflows at TOP; others at the MAX to zero roll
   assign ovf_set = tick && (dec.pwm ? top_hit :
      (!top_hit && cnt_ff == `T16W_MAX));
   assign cap_set = tick && top_hit &&
      (dec.top_src == t16w_pkg::T16W_TOP_CAP);

   // Set beats clear in the same cycle so no event is lost
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         ovf_ff <= 1'b0;
      end else begin
         ovf_ff <= ovf_set || (ovf_ff && !flag_clear_in.overflow);
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         capf_ff <= 1'b0;
      end else begin
         capf_ff <= cap_set || (capf_ff && !flag_clear_in.capture);
      end
   end

   // ****************************************
   // Compare channels
   // ****************************************
   logic [CHANNELS-1:0] mflag_ff;
   logic [CHANNELS-1:0] oc_ff;
   logic [CHANNELS-1:0] pin_ff;
   logic [CHANNELS-1:0] oe_ff;

   genvar gi;
   generate
      for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
         logic [15:0] buf_ff;
         logic [15:0] wdata;
         logic match;
         logic nxt_oc;
         logic [1:0] com;

         assign com = compare_output_mode_in[gi];
         assign wdata = compare_wr_in[gi].data & wmask;
         assign match = tick && !block_ff && (cnt_ff == ocr_ff[gi]);

         // Buffer always follows writes
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               buf_ff <= `T16W_BOTTOM;
            end else if (compare_wr_in[gi].strobe) begin
               buf_ff <= wdata;
            end
         end

         // Direct write outside PWM; copy from buffer at TOP in PWM
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               ocr_ff[gi] <= `T16W_BOTTOM;
            end else if (!dec.pwm && compare_wr_in[gi].strobe) begin
               ocr_ff[gi] <= wdata;
            end else if (dec.pwm && tick && top_hit) begin
               ocr_ff[gi] <= buf_ff;
            end
         end

         // Flag rises on the tick that leaves the matching count
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               mflag_ff[gi] <= 1'b0;
            end else begin
               mflag_ff[gi] <= match ||
                  (mflag_ff[gi] && !flag_clear_in.match[gi]);
            end
         end

         // Output action; match is applied last so compare equal to TOP holds level
         always_comb begin
            nxt_oc = oc_ff[gi];
            if (dec.pwm) begin
               if (tick && top_hit) begin
                  if (com == `T16W_COM_NONINV) begin
                     nxt_oc = 1'b0;
                  end else if (com == `T16W_COM_INV) begin
                     nxt_oc = 1'b1;
                  end
               end
               if (match) begin
                  if (com == `T16W_COM_NONINV) begin
                     nxt_oc = 1'b1;
                  end else if (com == `T16W_COM_INV) begin
                     nxt_oc = 1'b0;
                  end else if (com == `T16W_COM_TOGGLE && gi == 0 &&
                     dec.top_src == t16w_pkg::T16W_TOP_CMPA) begin
                     nxt_oc = !oc_ff[gi];
                  end
               end
            end else if (match || force_compare_strobe_in[gi]) begin
               case (com)
                  `T16W_COM_TOGGLE: nxt_oc = !oc_ff[gi];
                  `T16W_COM_NONINV: nxt_oc = 1'b0;
                  `T16W_COM_INV: nxt_oc = 1'b1;
                  default: nxt_oc = oc_ff[gi];
               endcase
            end
         end

         // Internal output bit, cleared by reset or by the output action
         // It keeps its value across waveform mode changes
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               oc_ff[gi] <= 1'b0;
            end else begin
               oc_ff[gi] <= nxt_oc;
            end
         end

         // Pin override needs a nonzero mode and output direction
         always_ff @(posedge clk_in) begin
            if (rst_in) begin
               pin_ff[gi] <= 1'b0;
               oe_ff[gi] <= 1'b0;
            end else begin
               pin_ff[gi] <= nxt_oc && pin_direction_in[gi];
               oe_ff[gi] <= pin_direction_in[gi] && (com != `T16W_COM_OFF);
            end
         end
      end
   endgenerate

   // ****************************************
   // Outputs
   // ****************************************
   // Ports come straight from registers, so they cannot glitch
   assign counter_value_out = cnt_ff;
   assign capture_value_out = cap_ff;
   assign compare_value_out = ocr_ff;
   assign flags_out.overflow = ovf_ff;
   assign flags_out.capture = capf_ff;
   assign flags_out.match = mflag_ff;
   assign compare_output_bit_out = oc_ff;
   assign pin_level_out = pin_ff;
   assign pin_oe_out = oe_ff;
endmodule // t16w_timer

// *** t16w_timer_asserts.sv ***
// Concurrent checks on the ports of the 16-bit timer waveform generator
`timescale 1ns/1ps
module t16w_timer_asserts #(
   parameter int CHANNELS = 2
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // Configuration and strobes
   input wire logic [3:0] waveform_mode_select_in,
   input wire logic [2:0] clock_select_in,
   input wire logic [CHANNELS-1:0][1:0] compare_output_mode_in,
   input wire t16w_pkg::t16w_wr_t counter_wr_in,
   input wire logic [CHANNELS-1:0] force_compare_strobe_in,
   input wire t16w_pkg::t16w_flags_t flag_clear_in,
   // Observed outputs
   input wire logic [15:0] counter_value_out,
   input wire logic [15:0] capture_value_out,
   input wire logic [CHANNELS-1:0][15:0] compare_value_out,
   input wire t16w_pkg::t16w_flags_t flags_out,
   input wire logic [CHANNELS-1:0] compare_output_bit_out
);
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // ****************************************
   // Helper state
   // ****************************************
   logic prev_wr_ff;
   logic fast;
   // A counter write blocks matches on the next tick, so remember it
   always_ff @(posedge clk_in) begin
      prev_wr_ff <= counter_wr_in.strobe;
   end
   // Match timing is exact only with a tick every cycle and no blocking
   assign fast = clock_select_in == 3'h1 && !counter_wr_in.strobe && !prev_wr_ff;
   // ****************************************
   // Properties
   // ****************************************
   norm_wrap_a: assert property (
      fast && waveform_mode_select_in == 4'h0 && counter_value_out == 16'hffff
      |=> counter_value_out == 16'h0000 && flags_out.overflow) else $error("bad normal wrap");
   ovf_hold_a: assert property (
      flags_out.overflow && !flag_clear_in.overflow |=> flags_out.overflow)
      else $error("overflow flag lost");
   ctc_top_a: assert property (
      fast && waveform_mode_select_in == 4'h4 && counter_value_out == compare_value_out[0]
      |=> counter_value_out == 16'h0000 && flags_out.match[0]) else $error("bad clear at A");
   cap_top_a: assert property (
      fast && waveform_mode_select_in == 4'hc && counter_value_out == capture_value_out
      |=> counter_value_out == 16'h0000 && flags_out.capture) else $error("bad clear at cap");
   fpwm_top_a: assert property (
      fast && waveform_mode_select_in == 4'h5 && counter_value_out == 16'h00ff
      |=> counter_value_out == 16'h0000 && flags_out.overflow) else $error("bad pwm top");
   buf_hold_a: assert property (
      waveform_mode_select_in == 4'h5 && clock_select_in == 3'h1 && counter_value_out != 16'h00ff
      |=> $stable(compare_value_out)) else $error("compare changed off top");
   force_tgl_a: assert property (
      force_compare_strobe_in[1] && waveform_mode_select_in == 4'h4 && clock_select_in == 3'h0
      && compare_output_mode_in[1] == 2'h1 && !counter_wr_in.strobe && flag_clear_in == '0
      |=> compare_output_bit_out[1] != $past(compare_output_bit_out[1])
      && $stable(counter_value_out) && $stable(flags_out)) else $error("bad forced toggle");
   off_hold_a: assert property (
      compare_output_mode_in[1] == 2'h0 |=> $stable(compare_output_bit_out[1]))
      else $error("output moved while off");
   // Main scenarios reached
   cover property (flags_out.overflow);
   cover property (flags_out.capture);
   cover property ($rose(compare_output_bit_out[1]));
   cover property ($rose(compare_output_bit_out[0]));
endmodule // t16w_timer_asserts

bind t16w_timer t16w_timer_asserts #(.CHANNELS(CHANNELS)) u_chk (
   .clk_in, .rst_in, .waveform_mode_select_in, .clock_select_in, .compare_output_mode_in,
   .counter_wr_in, .force_compare_strobe_in, .flag_clear_in, .counter_value_out,
   .capture_value_out, .compare_value_out, .flags_out, .compare_output_bit_out
);

// *** t16w_timer_test.sv ***
// Self-checking testbench of the 16-bit timer waveform generator
`timescale 1ns/1ps
module t16w_timer_test;
   // ****************************************
   // Stimulus and observed signals
   // ****************************************
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [3:0] md = 4'h0;
   logic [2:0] cs = 3'h0;
   logic [1:0][1:0] com = '0;
   logic [1:0] dir = 2'h0;
   logic [1:0] frc = 2'h0;
   t16w_pkg::t16w_wr_t cwr = '0;
   t16w_pkg::t16w_wr_t capwr = '0;
   t16w_pkg::t16w_wr_t [1:0] cmpwr = '0;
   t16w_pkg::t16w_flags_t fclr = '0;
   logic [15:0] cnt;
   logic [15:0] capv;
   logic [1:0][15:0] cmp;
   t16w_pkg::t16w_flags_t fl;
   logic [1:0] ob;
   logic [1:0] pl;
   logic [1:0] poe;
   int error_cnt = 0;
   int n_compared = 0;
   t16w_timer #(.CHANNELS(2)) u_dut (
      .clk_in(clk_in), .rst_in(rst_in), .waveform_mode_select_in(md), .clock_select_in(cs),
      .compare_output_mode_in(com), .pin_direction_in(dir), .counter_wr_in(cwr),
      .capture_wr_in(capwr), .compare_wr_in(cmpwr), .force_compare_strobe_in(frc),
      .flag_clear_in(fclr), .counter_value_out(cnt), .capture_value_out(capv),
      .compare_value_out(cmp), .flags_out(fl), .compare_output_bit_out(ob),
      .pin_level_out(pl), .pin_oe_out(poe)
   );
   // 40 MHz clock
   initial begin
      forever #12.5 clk_in = ~clk_in;
   end
   // ****************************************
   // Shared tasks
   // ****************************************
   // Inputs move 1 ns after the edge so the design never races the bench
   task automatic step(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic print_verdict();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Bounded wait for a count value; a miss ends the run
   task automatic wait_cnt(input logic [15:0] v);
      int i;
      for (i = 0; i < 8000 && cnt !== v; i++) step(1);
      if (i == 8000) begin
         error_cnt++;
         print_verdict();
      end
   endtask
   task automatic setcnt(input logic [15:0] v);
      cwr = {1'b1, v};
      step(1);
      cwr = '0;
   endtask
   task automatic clrf();
      fclr = '1;
      step(1);
      fclr = '0;
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic s_normal();
      cs = 3'h1;
      setcnt(16'hfffe);
      chk(cnt, 16'hfffe);
      wait_cnt(16'h0000);
      chk(fl.overflow, 1'b1);
      step(10);
      chk(fl.overflow, 1'b1);
      clrf();
      chk(fl.overflow, 1'b0);
   endtask
   task automatic s_presc();
      int divs[5] = '{1, 8, 64, 256, 1024};
      for (int k = 0; k < 5; k++) begin
         cs = 3'(k + 1);
         setcnt(16'h0000);
         wait_cnt(16'h0002);
         step(divs[k]);
         chk(cnt, 16'h0003);
      end
   endtask
   task automatic s_ctc();
      logic b;
      md = 4'h4;
      cs = 3'h1;
      com[0] = 2'h1;
      dir[0] = 1'b1;
      cmpwr[0] = {1'b1, 16'h0005};
      step(1);
      cmpwr[0] = '0;
      setcnt(16'h0000);
      clrf();
      wait_cnt(16'h0005);
      chk(fl.match[0], 1'b0);
      b = ob[0];
      step(1);
      chk(cnt, 16'h0000);
      chk(fl.match[0], 1'b1);
      chk(fl.overflow, 1'b0);
      chk(ob[0], !b);
      step(1);
      chk(pl[0], !b);
      chk(poe[0], 1'b1);
      // Start above TOP: the count must pass far beyond it
      setcnt(16'h0010);
      wait_cnt(16'h0040);
      // Past MAX the clear-on-match count still rolls and flags overflow
      clrf();
      setcnt(16'hfffe);
      wait_cnt(16'h0000);
      chk(fl.overflow, 1'b1);
   endtask
   task automatic s_cap();
      logic [3:0] mds[2] = '{4'hc, 4'he};
      for (int k = 0; k < 2; k++) begin
         md = mds[k];
         capwr = {1'b1, 16'h0007};
         step(1);
         capwr = '0;
         setcnt(16'h0000);
         clrf();
         wait_cnt(16'h0007);
         step(1);
         chk(cnt, 16'h0000);
         chk(fl.capture, 1'b1);
         chk(capv, 16'h0007);
      end
      chk(fl.overflow, 1'b1);
   endtask
   task automatic s_fpwm();
      logic [15:0] tops[3] = '{16'h00ff, 16'h01ff, 16'h03ff};
      logic [15:0] v;
      for (int k = 0; k < 3; k++) begin
         v = 16'h1234 & tops[k];
         md = 4'(5 + k);
         com[1] = 2'(2 + k % 2);
         cmpwr[1] = {1'b1, 16'h1234};
         step(1);
         cmpwr[1] = '0;
         setcnt(16'h0000);
         clrf();
         wait_cnt(tops[k]);
         step(1);
         chk(cnt, 16'h0000);
         chk(fl.overflow, 1'b1);
         chk(cmp[1], v);
         chk(ob[1], 16'(k % 2));
         wait_cnt(v + 16'h0001);
         chk(ob[1], 16'(1 - k % 2));
      end
   endtask
   // Channel A sets TOP and toggles; channel B at BOTTOM gives a one-cycle dip
   task automatic s_fpwm_a();
      logic b;
      md = 4'hf;
      com[0] = 2'h1;
      com[1] = 2'h2;
      cmpwr = {{1'b1, 16'h0000}, {1'b1, 16'h0007}};
      step(1);
      cmpwr = '0;
      setcnt(16'h0000);
      clrf();
      b = ob[0];
      // Old TOP of 5 still active until the first TOP copies the buffer
      wait_cnt(16'h0005);
      step(1);
      chk(cnt, 16'h0000);
      chk(cmp[0], 16'h0007);
      chk(fl.overflow, 1'b1);
      chk(fl.match[0], 1'b1);
      chk(ob[0], !b);
      chk(ob[1], 1'b0);
      step(1);
      chk(ob[1], 1'b1);
      wait_cnt(16'h0007);
      step(1);
      chk(ob[1], 1'b0);
      chk(ob[0], b);
      step(1);
      chk(ob[1], 1'b1);
   endtask
   // Stopped timer, so only the force can move the output
   task automatic s_force();
      logic [1:0] coms[3] = '{2'h1, 2'h3, 2'h2};
      logic [15:0] c;
      logic e;
      md = 4'h4;
      cs = 3'h0;
      clrf();
      c = cnt;
      // Strobe held high across the three forces, mode changes between edges
      frc[1] = 1'b1;
      for (int k = 0; k < 3; k++) begin
         com[1] = coms[k];
         e = k == 0 ? ~ob[1] : k == 1;
         step(1);
         chk(ob[1], e);
      end
      frc[1] = 1'b0;
      chk(cnt, c);
      chk(fl.match[1], 1'b0);
   endtask
   // Main sequence
   initial begin
      step(8);
      rst_in = 1'b0;
      s_normal();
      s_presc();
      s_ctc();
      s_cap();
      s_fpwm();
      s_fpwm_a();
      s_force();
      print_verdict();
   end
endmodule // t16w_timer_test
